// file: src/espfe_consts.svh
// Constants of the serial memory front end: widths, codes, reset values.
// Included by the package and by every design file that needs a number.
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
`ifndef ESPFE_CONSTS_SVH
`define ESPFE_CONSTS_SVH
`define ESPFE_MEM_BYTES  131072
`define ESPFE_PAGES      512
`define ESPFE_PAGE_BYTES 256
`define ESPFE_ADDR_W     17
`define ESPFE_OP_READ    8'h03
`define ESPFE_OP_WRITE   8'h02
`define ESPFE_ADDR_LAST  2'h2
`define ESPFE_BIT_LAST   3'h7
// Pin positions in the synchroniser vector
`define ESPFE_PIN_SCLK   4
`define ESPFE_PIN_CS     3
`define ESPFE_PIN_HOLD   2
`define ESPFE_PIN_SI     1
`define ESPFE_PIN_WP     0
// Idle pin levels: clock low, select high, hold high, data low, wp high
`define ESPFE_PIN_RST    5'h0d
`define ESPFE_GUARD_RST  2'h0
`define ESPFE_SO_RST     1'b0
`endif

// file: src/espfe_pkg.sv
// Types shared by the serial memory front end.
// Assumes espfe_consts.svh is on the include path.
`default_nettype none
`include "espfe_consts.svh"
package espfe_pkg;
  typedef enum logic [2:0] {
    PH_CMD     = 3'b000,
    PH_ADDR_RD = 3'b001,
    PH_ADDR_WR = 3'b010,
    PH_RDATA   = 3'b011,
    PH_WDATA   = 3'b100,
    PH_IGNORE  = 3'b101
  } espfe_state_e;
  typedef logic [`ESPFE_ADDR_W-1:0] espfe_addr_t;
endpackage : espfe_pkg
`default_nettype wire

// file: src/espfe_edge_if.sv
// Synchronised pin levels and their edges, from the sampler to the core.
// All signals are on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface espfe_edge_if;
  logic sclk;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic hold_n;
  logic hold_fall;
  logic hold_rise;
  logic si;
  logic wp_n;
  modport src (output sclk, sclk_rise, sclk_fall, cs_fall, cs_rise, hold_n, hold_fall, hold_rise, si, wp_n);
  modport dst (input sclk, sclk_rise, sclk_fall, cs_fall, cs_rise, hold_n, hold_fall, hold_rise, si, wp_n);
endinterface : espfe_edge_if
`default_nettype wire

// file: src/espfe_pin_sync.sv
// Two-flop synchronisers and edge detectors for the serial pins.
// Assumes the serial clock is far slower than clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "espfe_consts.svh"
module espfe_pin_sync
  import espfe_pkg::*;
(
  // System
  input  wire logic  clk_sys,
  input  wire logic  sys_rst,
  // Pins
  input  wire logic  sclk_pin,
  input  wire logic  cs_n_pin,
  input  wire logic  hold_n_pin,
  input  wire logic  si_pin,
  input  wire logic  wp_n_pin,
  // Levels and edges
  espfe_edge_if.src  ev
);
  logic [4:0] meta_reg, meta_next;
  logic [4:0] sync_reg, sync_next;
  logic [4:0] last_reg, last_next;

  //------------------------------------------------------------
  // Synchroniser chain
  //------------------------------------------------------------
  // Only sync_reg is looked at; the edge flop follows it
  always_comb begin
    meta_next = {sclk_pin, cs_n_pin, hold_n_pin, si_pin, wp_n_pin};
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= `ESPFE_PIN_RST;
      sync_reg <= `ESPFE_PIN_RST;
      last_reg <= `ESPFE_PIN_RST;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  //------------------------------------------------------------
  // Levels and edges
  //------------------------------------------------------------
  // Data and clock share equal delay, so si lines up with sclk edges
  assign ev.sclk      = sync_reg[`ESPFE_PIN_SCLK];
  assign ev.sclk_rise = sync_reg[`ESPFE_PIN_SCLK] & ~last_reg[`ESPFE_PIN_SCLK];
  assign ev.sclk_fall = ~sync_reg[`ESPFE_PIN_SCLK] & last_reg[`ESPFE_PIN_SCLK];
  assign ev.cs_fall   = ~sync_reg[`ESPFE_PIN_CS] & last_reg[`ESPFE_PIN_CS];
  assign ev.cs_rise   = sync_reg[`ESPFE_PIN_CS] & ~last_reg[`ESPFE_PIN_CS];
  assign ev.hold_n    = sync_reg[`ESPFE_PIN_HOLD];
  assign ev.hold_fall = ~sync_reg[`ESPFE_PIN_HOLD] & last_reg[`ESPFE_PIN_HOLD];
  assign ev.hold_rise = sync_reg[`ESPFE_PIN_HOLD] & ~last_reg[`ESPFE_PIN_HOLD];
  assign ev.si        = sync_reg[`ESPFE_PIN_SI];
  assign ev.wp_n      = sync_reg[`ESPFE_PIN_WP];
endmodule : espfe_pin_sync
`default_nettype wire

// file: src/espfe_core.sv
// Serial memory front end: bit capture, hold, byte read and write path.
// Assumes a slow serial clock sampled by clk_sys; status logic lies outside.
`timescale 1ns/1ps
`default_nettype none
`include "espfe_consts.svh"
module espfe_core
  import espfe_pkg::*;
#(
  parameter int         MEM_BYTES = `ESPFE_MEM_BYTES,
  parameter logic [7:0] OP_WRITE  = `ESPFE_OP_WRITE
) (
  // System
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Serial pins
  input  wire logic       sclk_pin,
  input  wire logic       cs_n_pin,
  input  wire logic       hold_n_pin,
  input  wire logic       si_pin,
  input  wire logic       wp_n_pin,
  output logic            so_out,
  output logic            so_oe,
  // Status side
  input  wire logic       write_busy,
  input  wire logic       block_guard_hi,
  input  wire logic       block_guard_lo,
  output logic            standby_mode,
  output logic [1:0]      guard_eff
);
  espfe_edge_if ev ();

  espfe_pin_sync u_sync (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .sclk_pin   (sclk_pin),
    .cs_n_pin   (cs_n_pin),
    .hold_n_pin (hold_n_pin),
    .si_pin     (si_pin),
    .wp_n_pin   (wp_n_pin),
    .ev         (ev)
  );

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  espfe_state_e state_reg, state_next;
  logic         sel_reg, sel_next;
  logic         hold_reg, hold_next;
  logic [2:0]   bit_cnt_reg, bit_cnt_next;
  logic [2:0]   out_cnt_reg, out_cnt_next;
  logic [1:0]   abyte_reg, abyte_next;
  logic [7:0]   shift_reg, shift_next;
  logic [7:0]   tx_reg, tx_next;
  espfe_addr_t  addr_reg, addr_next;
  logic         drive_reg, drive_next;
  logic         so_out_reg, so_out_next;
  logic         so_oe_reg, so_oe_next;
  logic         standby_reg, standby_next;
  logic [1:0]   guard_reg, guard_next;
  logic [7:0]   mem [0:MEM_BYTES-1];
  logic [7:0]   rx_byte;
  logic [7:0]   rd_byte;
  logic         run;
  logic         wr_en;

  // Address falls in the region that the guard setting protects
  function automatic logic guarded(input logic [1:0] g, input espfe_addr_t a);
    case (g)
      2'h1:    guarded = (a[16:15] == 2'h3);
      2'h2:    guarded = a[16];
      2'h3:    guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction : guarded

  //------------------------------------------------------------
  // Next-state logic
  //------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    sel_next     = sel_reg;
    hold_next    = hold_reg;
    bit_cnt_next = bit_cnt_reg;
    out_cnt_next = out_cnt_reg;
    abyte_next   = abyte_reg;
    shift_next   = shift_reg;
    tx_next      = tx_reg;
    addr_next    = addr_reg;
    drive_next   = drive_reg;
    so_out_next  = so_out_reg;
    wr_en        = 1'b0;
    rx_byte      = {shift_reg[6:0], ev.si};
    rd_byte      = mem[addr_reg];
    run          = sel_reg & ~hold_reg;
    if (ev.cs_fall) begin
      // Only a falling select arms the port; a select held low through reset counts as one, as the flops reset high
      sel_next     = 1'b1;
      hold_next    = 1'b0;
      state_next   = PH_CMD;
      bit_cnt_next = 3'h0;
      out_cnt_next = 3'h0;
      abyte_next   = 2'h0;
      drive_next   = 1'b0;
    end else if (ev.cs_rise) begin
      // Deselect drops any hold and the sequence in progress
      sel_next     = 1'b0;
      hold_next    = 1'b0;
      state_next   = PH_CMD;
      bit_cnt_next = 3'h0;
      drive_next   = 1'b0;
    end else begin
      // Hold edges with clock high take effect at the next clock fall
      if (!hold_reg && sel_reg && !ev.hold_n && !ev.sclk && (ev.hold_fall || ev.sclk_fall)) begin
        hold_next = 1'b1;
      end else if (hold_reg && ev.hold_n && !ev.sclk && (ev.hold_rise || ev.sclk_fall)) begin
        hold_next = 1'b0;
      end
      if (run && ev.sclk_rise) begin
        shift_next   = rx_byte;
        bit_cnt_next = bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == `ESPFE_BIT_LAST) begin
          case (state_reg)
            PH_CMD: begin
              if (rx_byte == `ESPFE_OP_READ) begin
                state_next = PH_ADDR_RD;
              end else if (rx_byte == OP_WRITE) begin
                state_next = PH_ADDR_WR;
              end else begin
                state_next = PH_IGNORE;
              end
              abyte_next = 2'h0;
            end
            PH_ADDR_RD, PH_ADDR_WR: begin
              addr_next  = {addr_reg[8:0], rx_byte};
              abyte_next = abyte_reg + 2'h1;
              if (abyte_reg == `ESPFE_ADDR_LAST) begin
                state_next   = (state_reg == PH_ADDR_RD) ? PH_RDATA : PH_WDATA;
                out_cnt_next = 3'h0;
              end
            end
            PH_WDATA: begin
              // Page writes wrap inside their 256-byte page
              wr_en     = ~guarded(guard_reg, addr_reg);
              addr_next = {addr_reg[16:8], addr_reg[7:0] + 8'h01};
            end
            default: begin
            end
          endcase
        end
      end
      if (run && ev.sclk_fall && state_reg == PH_RDATA) begin
        drive_next   = 1'b1;
        out_cnt_next = out_cnt_reg + 3'h1;
        if (out_cnt_reg == 3'h0) begin
          so_out_next = rd_byte[7];
          tx_next     = {rd_byte[6:0], 1'b0};
          addr_next   = addr_reg + 17'h00001;
        end else begin
          so_out_next = tx_reg[7];
          tx_next     = {tx_reg[6:0], 1'b0};
        end
      end
    end
    so_oe_next   = sel_next & ~hold_next & drive_next;
    standby_next = ~sel_next & ~write_busy;
    // Low write protect keeps the last guard setting
    guard_next   = ev.wp_n ? {block_guard_hi, block_guard_lo} : guard_reg;
  end

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= PH_CMD;
      sel_reg     <= 1'b0;
      hold_reg    <= 1'b0;
      bit_cnt_reg <= 3'h0;
      out_cnt_reg <= 3'h0;
      abyte_reg   <= 2'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      addr_reg    <= '0;
      drive_reg   <= 1'b0;
      so_out_reg  <= `ESPFE_SO_RST;
      so_oe_reg   <= 1'b0;
      standby_reg <= 1'b1;
      guard_reg   <= `ESPFE_GUARD_RST;
    end else begin
      state_reg   <= state_next;
      sel_reg     <= sel_next;
      hold_reg    <= hold_next;
      bit_cnt_reg <= bit_cnt_next;
      out_cnt_reg <= out_cnt_next;
      abyte_reg   <= abyte_next;
      shift_reg   <= shift_next;
      tx_reg      <= tx_next;
      addr_reg    <= addr_next;
      drive_reg   <= drive_next;
      so_out_reg  <= so_out_next;
      so_oe_reg   <= so_oe_next;
      standby_reg <= standby_next;
      guard_reg   <= guard_next;
    end
  end

  // Array has no reset; contents are what was last written
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[addr_reg] <= rx_byte;
    end
  end

  assign so_out       = so_out_reg;
  assign so_oe        = so_oe_reg;
  assign standby_mode = standby_reg;
  assign guard_eff    = guard_reg;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence seq_read_start;
    run && ev.sclk_fall && state_reg == PH_RDATA && out_cnt_reg == 3'h0;
  endsequence

  chk_deselect_float: assert property (!sel_reg |-> !so_oe_reg)
    else $error("output driven while deselected");
  chk_hold_float: assert property (hold_reg |-> !so_oe_reg)
    else $error("output driven during hold");
  chk_out_on_fall: assert property ($changed(so_out_reg) |-> $past(ev.sclk_fall))
    else $error("output changed without clock fall");
  chk_count_restart: assert property (ev.cs_fall |=> bit_cnt_reg == 3'h0 && sel_reg)
    else $error("bit count not restarted on select");
  chk_msb_shift: assert property (run && ev.sclk_rise |=> shift_reg[0] == $past(ev.si))
    else $error("input bit not captured on clock rise");
  chk_select_edge: assert property ($rose(sel_reg) |-> $past(ev.cs_fall))
    else $error("selected without select falling edge");
  chk_hold_ignore: assert property (hold_reg && ev.sclk_rise && !ev.cs_rise |=> $stable(bit_cnt_reg))
    else $error("bit count moved during hold");
  chk_deselect_reset: assert property (ev.cs_rise |=> state_reg == PH_CMD && !hold_reg)
    else $error("deselect did not reset sequence");
  chk_standby_mode: assert property (sel_reg |-> !standby_reg)
    else $error("standby while selected");
  chk_guard_freeze: assert property (!ev.wp_n |=> $stable(guard_reg))
    else $error("guard changed while write protected");
  chk_first_out: assert property (seq_read_start |=> so_oe_reg ##0 so_out_reg == $past(rd_byte[7]))
    else $error("first read bit not msb of byte");
  // Writable area decoded apart from the write path, so a broken decode is caught
  logic wr_allowed;
  assign wr_allowed = (guard_reg == 2'h0) | ((guard_reg == 2'h1) & (~&addr_reg[16:15])) |
                      ((guard_reg == 2'h2) & ~addr_reg[16]);
  chk_guard_write: assert property (wr_en |-> wr_allowed)
    else $error("write into guarded region");
endmodule : espfe_core
`default_nettype wire

// file: sim/espfe_master_model.sv
// SPI bus master model for the serial memory front end, modes 0,0 and 1,1.
// Assumes the bench resolves the data-out wire and calls these tasks in order.
`timescale 1ns/1ps
`default_nettype none
module espfe_master_model (
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      hold_n,
  output logic      si,
  // Resolved data out
  input  wire logic so
);
  logic       cpol;
  logic [7:0] rx_byte;
  event       rx_done;
  //------------------------------------------------------------
  // Pin tasks
  //------------------------------------------------------------
  // Park idle: the clock stands still at the mode level between frames
  initial begin
    cpol   = 1'b0;
    sclk   = 1'b0;
    cs_n   = 1'b1;
    hold_n = 1'b1;
    si     = 1'b0;
  end
  // Only called while deselected, so the level change makes no stray edge
  task automatic mode(input logic m);
    cpol = m;
    sclk = m;
  endtask : mode
  // Select edge first; the synchroniser needs a few cycles to see it
  task automatic sel();
    cs_n = 1'b0;
    #40;
  endtask : sel
  task automatic desel();
    sclk = cpol;
    #32;
    cs_n = 1'b1;
    #64;
  endtask : desel
  // Bits go out MSB first in the low phase, read data is taken at the rise
  task automatic xfer(input logic [7:0] tx, input bit watch, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      sclk = 1'b0;
      si   = tx[i];
      #32;
      sclk = 1'b1;
      rx_byte[i] = so;
      #32;
    end
    if (watch) ->rx_done;
  endtask : xfer
  // Hold begins and ends with the clock low; clock and data wiggle meanwhile
  task automatic pause(input int pulses);
    sclk = 1'b0;
    #32;
    hold_n = 1'b0;
    #40;
    repeat (pulses) begin
      sclk = 1'b1;
      si   = ~si;
      #32;
      sclk = 1'b0;
      #32;
    end
  endtask : pause
  task automatic resume();
    hold_n = 1'b1;
    #40;
  endtask : resume
endmodule : espfe_master_model
`default_nettype wire

// file: sim/eeprom_serial_port_front_end_tb.sv
// Self-checking bench for the serial memory front end with a master model.
// Assumes espfe_consts.svh on the include path and a 64 ns serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "espfe_consts.svh"
module eeprom_serial_port_front_end_tb;
  import espfe_pkg::*;
  logic       clk_sys, sys_rst, wp_n, write_busy, guard_hi, guard_lo;
  logic       sclk, cs_n, hold_n, si, so_out, so_oe, standby_mode;
  logic       float_pat = 1'b0;
  logic [1:0] guard_eff;
  logic [7:0] exp_q[$];
  logic [7:0] shadow[int];
  logic [7:0] junk;
  logic [16:0] base;
  int         num_errors, checked, cycles, seed;
  //------------------------------------------------------------
  // Design, far side and wire
  //------------------------------------------------------------
  espfe_core espfe_core_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk_pin(sclk), .cs_n_pin(cs_n),
    .hold_n_pin(hold_n), .si_pin(si), .wp_n_pin(wp_n), .so_out(so_out), .so_oe(so_oe),
    .write_busy(write_busy), .block_guard_hi(guard_hi), .block_guard_lo(guard_lo),
    .standby_mode(standby_mode), .guard_eff(guard_eff));
  espfe_master_model espfe_master_model_i (.sclk(sclk), .cs_n(cs_n), .hold_n(hold_n), .si(si),
    .so(float_pat ^ (so_oe & (so_out ^ float_pat))));
  // Clock; a floating data line must never look like a stable bit
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) float_pat <= ~float_pat;
  //------------------------------------------------------------
  // Checking
  //------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // Each read byte seen by the master is matched with the oldest note
  always @(espfe_master_model_i.rx_done) begin
    check("read byte", espfe_master_model_i.rx_byte, exp_q.pop_front());
  end
  // Hang guard, well above the nearly ten thousand cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      close_out();
    end
  end
  //------------------------------------------------------------
  // Transfers
  //------------------------------------------------------------
  // Top address bits beyond the array are random junk and must be dropped
  task automatic cmd(input logic [7:0] op, input logic [16:0] a);
    junk = 8'($random(seed));
    espfe_master_model_i.sel();
    espfe_master_model_i.xfer(op, 1'b0, 8);
    espfe_master_model_i.xfer({junk[7:1], a[16]}, 1'b0, 8);
    espfe_master_model_i.xfer(a[15:8], 1'b0, 8);
    espfe_master_model_i.xfer(a[7:0], 1'b0, 8);
  endtask : cmd
  // Writes wrap inside the page; trailing partial bits must not store
  task automatic wr(input logic [16:0] a, input int n, input bit keep, input int nb);
    logic [7:0] d;
    cmd(`ESPFE_OP_WRITE, a);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      if (keep) shadow[{a[16:8], a[7:0] + i[7:0]}] = d;
      espfe_master_model_i.xfer(d, 1'b0, 8);
    end
    espfe_master_model_i.xfer(8'h5a, 1'b0, nb);
    espfe_master_model_i.desel();
  endtask : wr
  // Streaming read, with an optional hold in front of byte hold_at
  task automatic rd(input logic [16:0] a, input int n, input int hold_at);
    logic [16:0] p;
    cmd(`ESPFE_OP_READ, a);
    for (int i = 0; i < n; i++) begin
      p = a + i[16:0];
      if (i == hold_at) begin
        espfe_master_model_i.pause(3);
        check("oe in hold", {7'h00, so_oe}, 8'h00);
        espfe_master_model_i.resume();
      end
      exp_q.push_back(shadow[p]);
      espfe_master_model_i.xfer(8'hff, 1'b1, 8);
    end
    espfe_master_model_i.desel();
    check("oe deselected", {7'h00, so_oe}, 8'h00);
  endtask : rd
  // Write protect moves first: its pin is synchronised, the guard level is not
  task automatic side(input logic [1:0] g, input logic w, input logic b);
    @(negedge clk_sys);
    wp_n = w;
    repeat (4) @(negedge clk_sys);
    {guard_hi, guard_lo} = g;
    write_busy = b;
    repeat (6) @(negedge clk_sys);
  endtask : side
  //------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------
  initial begin
    seed = 78;
    {sys_rst, wp_n, write_busy, guard_hi, guard_lo} = 5'h18;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    check("reset state", {5'h00, standby_mode, guard_eff}, 8'h04);
    base = 17'($random(seed));
    base[7:0] = 8'hfe;
    wr(base, 5, 1'b1, 0);
    wr({base[16:8], 8'h02}, 0, 1'b0, 4);
    espfe_master_model_i.mode(1'b1);
    rd({base[16:8], 8'h00}, 3, -1);
    rd(base, 2, -1);
    $display("test write wrap and read done");
    // Fill the next page so the streaming read below crosses into known data
    wr({base[16:8] + 9'h001, 8'h00}, 2, 1'b1, 0);
    rd(base, 4, 2);
    espfe_master_model_i.mode(1'b0);
    cmd(`ESPFE_OP_READ, base);
    espfe_master_model_i.pause(1);
    espfe_master_model_i.desel();
    espfe_master_model_i.resume();
    rd(base, 2, 1);
    $display("test hold done");
    side(2'h3, 1'b1, 1'b0);
    check("guard set", {6'h00, guard_eff}, 8'h03);
    side(2'h1, 1'b0, 1'b0);
    check("guard frozen", {6'h00, guard_eff}, 8'h03);
    wr({base[16:8], 8'h00}, 1, 1'b0, 0);
    rd({base[16:8], 8'h00}, 1, -1);
    side(2'h1, 1'b1, 1'b0);
    check("guard thawed", {6'h00, guard_eff}, 8'h01);
    side(2'h0, 1'b1, 1'b1);
    $display("test write guard done");
    espfe_master_model_i.sel();
    check("active", {7'h00, standby_mode}, 8'h00);
    espfe_master_model_i.desel();
    check("busy", {7'h00, standby_mode}, 8'h00);
    side(2'h0, 1'b1, 1'b0);
    check("standby", {7'h00, standby_mode}, 8'h01);
    $display("test power mode done");
    for (int k = 0; k < 4; k++) begin
      junk = 8'($random(seed));
      if (junk == `ESPFE_OP_READ || junk == `ESPFE_OP_WRITE) junk = 8'h06;
      cmd(junk, base);
      espfe_master_model_i.xfer(8'h00, 1'b0, 8);
      check("oe bad code", {7'h00, so_oe}, 8'h00);
      espfe_master_model_i.desel();
      espfe_master_model_i.sel();
      espfe_master_model_i.xfer(8'h03, 1'b0, 3);
      espfe_master_model_i.desel();
    end
    rd(base, 1, -1);
    $display("test bad codes done");
    close_out();
  end
endmodule : eeprom_serial_port_front_end_tb
`default_nettype wire
